// ---- logic/ufc_pkg.sv ----
// shared constants and types for the device address / frame / endpoint control block
package ufc_pkg;
    // register indices on the register port
    localparam logic [3:0] UFC_IDX_ADDR = 4'h0;
    localparam logic [3:0] UFC_IDX_FRM_LO = 4'h1;
    localparam logic [3:0] UFC_IDX_FRM_HI = 4'h2;
    localparam logic [3:0] UFC_IDX_EP_BASE = 4'h3;
    localparam logic [3:0] UFC_IDX_EP_LAST = 4'h9;
    localparam int UFC_NUM_EP = 7;
    // field positions inside an endpoint control register
    localparam int UFC_EP_CTLDIS = 4;
    localparam int UFC_EP_RXEN = 3;
    localparam int UFC_EP_TXEN = 2;
    localparam int UFC_EP_HALT = 1;
    localparam int UFC_EP_HSHK = 0;
    // reset values and recommended endpoint zero setting
    localparam logic [7:0] UFC_ADDR_RST = 8'h00;
    localparam logic [7:0] UFC_EP_RST = 8'h00;
    localparam logic [10:0] UFC_FRM_RST = 11'h000;
    localparam logic [7:0] UFC_EP0_DEFAULT = 8'h0D;
    // token kinds on the link
    typedef enum logic [1:0] {
        UFC_TOK_OUT = 2'b00,
        UFC_TOK_IN = 2'b01,
        UFC_TOK_SETUP = 2'b10,
        UFC_TOK_SOF = 2'b11
    } ufc_tok_t;
    // handshake answers on the link
    typedef enum logic [1:0] {
        UFC_HS_NONE = 2'b00,
        UFC_HS_ACK = 2'b01,
        UFC_HS_NAK = 2'b10,
        UFC_HS_STALL = 2'b11
    } ufc_hs_t;
endpackage

// ---- logic/ufc_link_if.sv ----
// token/handshake link between the host end and the device end
interface ufc_link_if;
    import ufc_pkg::*;
    logic tok_valid;
    ufc_tok_t tok_kind;
    logic [6:0] tok_addr;
    logic [3:0] tok_endp;
    logic [10:0] tok_frame;
    logic bus_reset;
    logic hs_valid;
    ufc_hs_t hs_code;
    modport host (
        output tok_valid, tok_kind, tok_addr, tok_endp, tok_frame, bus_reset,
        input hs_valid, hs_code
    );
    modport device (
        input tok_valid, tok_kind, tok_addr, tok_endp, tok_frame, bus_reset,
        output hs_valid, hs_code
    );
endinterface

// ---- logic/ufc_ep_decode.sv ----
// decodes one endpoint control value into its answer for a token kind
module ufc_ep_decode
    import ufc_pkg::*;
(
    // control value and token
    input wire logic [7:0] i_ctl,
    input wire ufc_tok_t i_kind,
    // decoded answer
    output logic o_enabled,
    output ufc_hs_t o_hs
);
    logic rx_en;
    logic tx_en;
    logic accepts;
    assign rx_en = i_ctl[UFC_EP_RXEN];
    assign tx_en = i_ctl[UFC_EP_TXEN];
    assign o_enabled = rx_en | tx_en;
    // direction check; bit 4 only matters with both enables set
    always_comb begin
        case (i_kind)
            UFC_TOK_IN: accepts = tx_en;
            UFC_TOK_OUT: accepts = rx_en;
            UFC_TOK_SETUP: accepts = rx_en & tx_en & ~i_ctl[UFC_EP_CTLDIS];
            default: accepts = 1'b0;
        endcase
    end
    // halt outranks everything but only while the endpoint is enabled
    always_comb begin
        if (!o_enabled) begin
            o_hs = UFC_HS_NONE;
        end else if (i_ctl[UFC_EP_HALT]) begin
            o_hs = UFC_HS_STALL;
        end else if (!i_ctl[UFC_EP_HSHK]) begin
            o_hs = UFC_HS_NONE;
        end else if (accepts) begin
            o_hs = UFC_HS_ACK;
        end else begin
            o_hs = UFC_HS_NONE;
        end
    end
endmodule

// ---- logic/ufc_device.sv ----
// device end: address, frame number and endpoint control registers
// Summary of operation
// - device holds seven-bit address it answers to
// - reset or bus reset clears address
// - software writes new address during SET_ADDRESS
// - frame number split low byte, high bits
// - every SOF token loads frame number
// - seven endpoint control registers, numbers 0-6
// - software writes 0x0D to endpoint zero
// - enables select disabled, IN-only, OUT-only
// - both enables, bit4 clear: IN/OUT/SETUP
// - halt bit answers every access with STALL
// - halt honoured only while endpoint enabled
// - handshake bit clear suppresses handshake phase unless halt is set
// - keep handshake set except isochronous
// - stalled endpoint stays stalled until cleared
module ufc_device
    import ufc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_idx,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // status
    output logic o_bus_reset_seen,
    // link
    ufc_link_if.device link
);
    logic [6:0] addr_reg;
    logic [10:0] frame_reg;
    logic [7:0] ep_ctl_reg [UFC_NUM_EP];
    logic [7:0] reg_rdata_reg;
    logic reg_rvalid_reg;
    logic bus_reset_seen_reg;
    logic hs_valid_reg;
    ufc_hs_t hs_code_reg;
    logic [UFC_NUM_EP-1:0] ep_enabled;
    ufc_hs_t ep_hs [UFC_NUM_EP];
    logic addr_match;
    logic ep_in_range;
    logic [2:0] ep_sel;
    logic ep_wr_hit;
    logic [3:0] ep_wr_off;

    assign addr_match = link.tok_addr == addr_reg;
    assign ep_in_range = link.tok_endp < 4'(UFC_NUM_EP);
    assign ep_sel = link.tok_endp[2:0];
    assign ep_wr_off = 4'(i_reg_idx - UFC_IDX_EP_BASE);
    assign ep_wr_hit = i_reg_wr && i_reg_idx >= UFC_IDX_EP_BASE && i_reg_idx <= UFC_IDX_EP_LAST;

    // one decoder per endpoint
    genvar g;
    generate
        for (g = 0; g < UFC_NUM_EP; g++) begin : g_ep
            ufc_ep_decode u_dec (
                .i_ctl(ep_ctl_reg[g]),
                .i_kind(link.tok_kind),
                .o_enabled(ep_enabled[g]),
                .o_hs(ep_hs[g])
            );
        end
    endgenerate

    // device address; bus reset outranks a same-cycle software write
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || link.bus_reset) begin
            addr_reg <= UFC_ADDR_RST[6:0];
        end else if (i_reg_wr && i_reg_idx == UFC_IDX_ADDR) begin
            addr_reg <= i_reg_wdata[6:0];
        end
    end

    // frame number from every SOF, whatever its address field
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || link.bus_reset) begin
            frame_reg <= UFC_FRM_RST;
        end else if (link.tok_valid && link.tok_kind == UFC_TOK_SOF) begin
            frame_reg <= link.tok_frame;
        end
    end

    // endpoint control; halt cleared by a software write, reset or bus reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || link.bus_reset) begin
            for (int i = 0; i < UFC_NUM_EP; i++) begin
                ep_ctl_reg[i] <= UFC_EP_RST;
            end
        end else if (ep_wr_hit) begin
            ep_ctl_reg[ep_wr_off[2:0]] <= {3'h0, i_reg_wdata[4:0]};
        end
    end

    // sticky bus reset flag; a new reset beats a read-clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            bus_reset_seen_reg <= 1'b0;
        end else if (link.bus_reset) begin
            bus_reset_seen_reg <= 1'b1;
        end else if (i_reg_rd && i_reg_idx == UFC_IDX_ADDR) begin
            bus_reset_seen_reg <= 1'b0;
        end
    end

    // register read, one cycle latency
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            reg_rdata_reg <= 8'h00;
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= i_reg_rd;
            if (i_reg_rd) begin
                if (i_reg_idx == UFC_IDX_ADDR) begin
                    reg_rdata_reg <= {1'b0, addr_reg};
                end else if (i_reg_idx == UFC_IDX_FRM_LO) begin
                    reg_rdata_reg <= frame_reg[7:0];
                end else if (i_reg_idx == UFC_IDX_FRM_HI) begin
                    reg_rdata_reg <= {5'h00, frame_reg[10:8]};
                end else if (i_reg_idx >= UFC_IDX_EP_BASE && i_reg_idx <= UFC_IDX_EP_LAST) begin
                    reg_rdata_reg <= ep_ctl_reg[ep_wr_off[2:0]];
                end else begin
                    reg_rdata_reg <= 8'h00;
                end
            end
        end
    end

    // handshake answer, one cycle after the token
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || link.bus_reset) begin
            hs_valid_reg <= 1'b0;
            hs_code_reg <= UFC_HS_NONE;
        end else if (link.tok_valid && link.tok_kind != UFC_TOK_SOF && addr_match && ep_in_range
                     && ep_enabled[ep_sel] && ep_hs[ep_sel] != UFC_HS_NONE) begin
            hs_valid_reg <= 1'b1;
            hs_code_reg <= ep_hs[ep_sel];
        end else begin
            hs_valid_reg <= 1'b0;
            hs_code_reg <= UFC_HS_NONE;
        end
    end

    assign o_reg_rdata = reg_rdata_reg;
    assign o_reg_rvalid = reg_rvalid_reg;
    assign o_bus_reset_seen = bus_reset_seen_reg;
    assign link.hs_valid = hs_valid_reg;
    assign link.hs_code = hs_code_reg;
endmodule

// ---- logic/ufc_host.sv ----
// host end: issues tokens and bus reset, collects handshakes
module ufc_host
    import ufc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // user request
    input wire logic i_req,
    input wire ufc_tok_t i_req_kind,
    input wire logic [6:0] i_req_addr,
    input wire logic [3:0] i_req_endp,
    input wire logic [10:0] i_req_frame,
    input wire logic i_req_bus_reset,
    // user answer
    output logic o_busy,
    output logic o_done,
    output logic o_got_hs,
    output ufc_hs_t o_hs_code,
    // link
    ufc_link_if.host link
);
    typedef enum logic [1:0] {
        UFC_H_IDLE = 2'b00,
        UFC_H_WAIT = 2'b01,
        UFC_H_ANSWER = 2'b10
    } ufc_hstate_t;
    ufc_hstate_t state_reg;
    logic tok_valid_reg;
    ufc_tok_t tok_kind_reg;
    logic [6:0] tok_addr_reg;
    logic [3:0] tok_endp_reg;
    logic [10:0] tok_frame_reg;
    logic bus_reset_reg;
    logic done_reg;
    logic got_hs_reg;
    ufc_hs_t hs_code_reg;

    // token issue; wait one answer slot after each token
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_reg <= UFC_H_IDLE;
            tok_valid_reg <= 1'b0;
            tok_kind_reg <= UFC_TOK_OUT;
            tok_addr_reg <= 7'h00;
            tok_endp_reg <= 4'h0;
            tok_frame_reg <= 11'h000;
            bus_reset_reg <= 1'b0;
        end else begin
            tok_valid_reg <= 1'b0;
            bus_reset_reg <= 1'b0;
            case (state_reg)
                UFC_H_IDLE: begin
                    if (i_req_bus_reset) begin
                        bus_reset_reg <= 1'b1;
                    end else if (i_req) begin
                        tok_valid_reg <= 1'b1;
                        tok_kind_reg <= i_req_kind;
                        tok_addr_reg <= i_req_addr;
                        tok_endp_reg <= i_req_endp;
                        tok_frame_reg <= i_req_frame;
                        state_reg <= UFC_H_WAIT;
                    end
                end
                // device answer stands in the answer slot; done reports it the cycle after
                UFC_H_WAIT: state_reg <= UFC_H_ANSWER;
                UFC_H_ANSWER: state_reg <= UFC_H_IDLE;
                default: state_reg <= UFC_H_IDLE;
            endcase
        end
    end

    // handshake capture, reported two cycles after the token
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            done_reg <= 1'b0;
            got_hs_reg <= 1'b0;
            hs_code_reg <= UFC_HS_NONE;
        end else begin
            done_reg <= state_reg == UFC_H_ANSWER;
            if (tok_valid_reg) begin
                got_hs_reg <= 1'b0;
                hs_code_reg <= UFC_HS_NONE;
            end else if (link.hs_valid) begin
                got_hs_reg <= 1'b1;
                hs_code_reg <= link.hs_code;
            end
        end
    end

    assign o_busy = state_reg != UFC_H_IDLE || tok_valid_reg;
    assign o_done = done_reg;
    assign o_got_hs = got_hs_reg;
    assign o_hs_code = hs_code_reg;
    assign link.tok_valid = tok_valid_reg;
    assign link.tok_kind = tok_kind_reg;
    assign link.tok_addr = tok_addr_reg;
    assign link.tok_endp = tok_endp_reg;
    assign link.tok_frame = tok_frame_reg;
    assign link.bus_reset = bus_reset_reg;
endmodule

// ---- tb/ufc_chk.sv ----
// link checker: handshake timing and causes seen across the token link
module ufc_chk
    import ufc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // host to device
    input wire logic tok_valid,
    input wire ufc_tok_t tok_kind,
    input wire logic [6:0] tok_addr,
    input wire logic [3:0] tok_endp,
    input wire logic [10:0] tok_frame,
    input wire logic bus_reset,
    // device to host
    input wire logic hs_valid,
    input wire ufc_hs_t hs_code
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // answers come only one cycle after a non-frame token
    hs_cause_a: assert property (hs_valid |-> $past(tok_valid) && $past(tok_kind) != UFC_TOK_SOF)
        else $error("handshake without a token");
    sof_silent_a: assert property (tok_valid && tok_kind == UFC_TOK_SOF |=> !hs_valid)
        else $error("frame token answered");
    ep_range_a: assert property (tok_valid && tok_endp > 4'h6 |=> !hs_valid)
        else $error("token to missing endpoint answered");
    // a handshake phase always carries a real code
    hs_code_a: assert property (hs_valid |-> hs_code != UFC_HS_NONE)
        else $error("handshake phase with empty code");
    no_nak_a: assert property (hs_valid |-> hs_code inside {UFC_HS_ACK, UFC_HS_STALL})
        else $error("handshake code not ack or stall");
    hs_pulse_a: assert property (hs_valid |=> !hs_valid)
        else $error("handshake longer than one cycle");
    // endpoints are cleared, so a token soon after bus reset stays unanswered
    bus_rst_a: assert property (bus_reset ##[1:6] tok_valid |=> !hs_valid)
        else $error("token answered after bus reset");
    tok_pulse_a: assert property (tok_valid |=> !tok_valid)
        else $error("token longer than one cycle");
    cover property (hs_valid && hs_code == UFC_HS_STALL);
    cover property (hs_valid && hs_code == UFC_HS_ACK);
    cover property (tok_valid && tok_kind == UFC_TOK_SOF);
endmodule

// ---- tb/ufc_bench.sv ----
// self-checking bench joining the host end and the device end
module ufc_bench
    import ufc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, req = 1'b0, brst = 1'b0;
    logic [3:0] idx = 4'h0, endp = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [6:0] addr = 7'h00;
    logic [10:0] frame = 11'h000;
    logic rvalid, brst_seen, busy, done, got_hs;
    ufc_tok_t kind = UFC_TOK_OUT;
    ufc_hs_t hs;
    int mismatches = 0, tests_run = 0, cycles = 0;
    logic [7:0] vals [8] = '{8'h00, 8'hE5, 8'h09, 8'h0C, 8'h0F, 8'h0D, 8'h03, 8'h01};
    ufc_link_if link();
    ufc_device ufc_device_i(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_idx(idx), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_bus_reset_seen(brst_seen), .link(link));
    ufc_host ufc_host_i(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req),
        .i_req_kind(kind), .i_req_addr(addr), .i_req_endp(endp), .i_req_frame(frame),
        .i_req_bus_reset(brst), .o_busy(busy), .o_done(done), .o_got_hs(got_hs),
        .o_hs_code(hs), .link(link));
    ufc_chk ufc_chk_i(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .tok_valid(link.tok_valid),
        .tok_kind(link.tok_kind), .tok_addr(link.tok_addr), .tok_endp(link.tok_endp),
        .tok_frame(link.tok_frame), .bus_reset(link.bus_reset), .hs_valid(link.hs_valid),
        .hs_code(link.hs_code));
    // 250 MHz clock
    always #2 i_clk_sys = ~i_clk_sys;
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic write_reg(input logic [3:0] i, input logic [7:0] d);
        @(negedge i_clk_sys);
        wr = 1'b1;
        idx = i;
        wdata = d;
        @(negedge i_clk_sys);
        wr = 1'b0;
    endtask
    // read data stands one cycle after the strobe
    task automatic read_reg(input logic [3:0] i, input logic [7:0] exp);
        @(negedge i_clk_sys);
        rd = 1'b1;
        idx = i;
        @(negedge i_clk_sys);
        rd = 1'b0;
        check(rvalid === 1'b1 ? rdata : ~exp, exp);
    endtask
    // one token, then wait for the host to report its outcome
    task automatic send(input ufc_tok_t k, input logic [6:0] a, input logic [3:0] e,
                        input logic [10:0] f, input ufc_hs_t ec);
        int n;
        @(negedge i_clk_sys);
        req = 1'b1;
        kind = k;
        addr = a;
        endp = e;
        frame = f;
        @(negedge i_clk_sys);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(negedge i_clk_sys);
            n++;
        end
        check({4'h0, done, got_hs, got_hs ? hs : UFC_HS_NONE}, {4'h0, 1'b1, ec != UFC_HS_NONE, ec});
    endtask
    // expected answer worked out from the endpoint control bits
    function automatic ufc_hs_t want(input logic [7:0] c, input ufc_tok_t k);
        if (!(c[3] | c[2]))
            return UFC_HS_NONE;
        if (c[1])
            return UFC_HS_STALL;
        if (!c[0])
            return UFC_HS_NONE;
        if ((k == UFC_TOK_IN && c[2]) || (k == UFC_TOK_OUT && c[3]) ||
            (k == UFC_TOK_SETUP && c[3] && c[2] && !c[4]))
            return UFC_HS_ACK;
        return UFC_HS_NONE;
    endfunction
    // main sequence
    initial begin
        repeat (3) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        for (int i = 0; i < 11; i++) read_reg(4'(i), 8'h00);
        write_reg(UFC_IDX_ADDR, 8'hFF);
        read_reg(UFC_IDX_ADDR, 8'h7F);
        write_reg(UFC_IDX_ADDR, 8'h05);
        write_reg(UFC_IDX_EP_BASE, 8'h0D);
        send(UFC_TOK_SETUP, 7'h00, 4'h0, 11'h000, UFC_HS_NONE);
        send(UFC_TOK_SETUP, 7'h05, 4'h0, 11'h000, UFC_HS_ACK);
        send(UFC_TOK_SOF, 7'h33, 4'h0, 11'h5A3, UFC_HS_NONE);
        write_reg(UFC_IDX_FRM_LO, 8'h00);
        read_reg(UFC_IDX_FRM_LO, 8'hA3);
        read_reg(UFC_IDX_FRM_HI, 8'h05);
        // stall survives three tokens in a row, then a write releases it
        for (int v = 0; v < 8; v++) begin
            write_reg(UFC_IDX_EP_BASE + 4'h1, vals[v]);
            read_reg(UFC_IDX_EP_BASE + 4'h1, vals[v] & 8'h1F);
            for (int k = 0; k < 3; k++) send(ufc_tok_t'(k), 7'h05, 4'h1, 11'h000, want(vals[v], ufc_tok_t'(k)));
        end
        send(UFC_TOK_IN, 7'h05, 4'h7, 11'h000, UFC_HS_NONE);
        @(negedge i_clk_sys);
        brst = 1'b1;
        @(negedge i_clk_sys);
        brst = 1'b0;
        send(UFC_TOK_SETUP, 7'h00, 4'h0, 11'h000, UFC_HS_NONE);
        check({7'h00, brst_seen}, 8'h01);
        read_reg(UFC_IDX_ADDR, 8'h00);
        check({7'h00, brst_seen}, 8'h00);
        read_reg(UFC_IDX_FRM_LO, 8'h00);
        read_reg(UFC_IDX_EP_BASE, 8'h00);
        write_reg(UFC_IDX_EP_BASE, UFC_EP0_DEFAULT);
        send(UFC_TOK_SETUP, 7'h00, 4'h0, 11'h000, UFC_HS_ACK);
        give_verdict();
    end
endmodule
